// File: hdl/flash_cmd_seq.sv
/*
  Serial flash erase/program/wrap command sequencer.
  Samples chip select, serial clock and serial input on the system clock,
  decodes the command frames, checks framing, write enable and block
  protection, and runs self-timed internal cycles shown on write_busy.
  Assumes the serial clock is well below a quarter of sys_clk, mode 0/3
  sampling on the rising serial edge, and that the array performs the
  command on array_start_o, reading program bytes from the page buffer.
*/
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

module flash_cmd_seq
  import flash_seq_pkg::*;
#(
  parameter int unsigned PAGE_CLEAR_CYCLES =
    `PAGE_CLEAR_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned MID_CLEAR_CYCLES =
    `MID_CLEAR_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned HALF_CLEAR_CYCLES =
    `HALF_CLEAR_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned REGION_CLEAR_CYCLES =
    `REGION_CLEAR_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned WHOLE_CLEAR_CYCLES =
    `WHOLE_CLEAR_TIME_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned PAGE_WRITE_CYCLES =
    `PAGE_WRITE_TIME_US * 1000 / `CLK_PERIOD_NS
) (
  input  wire logic          sys_clk_i,
  input  wire logic          reset_i,
  input  wire logic          cs_n_i,
  input  wire logic          sclk_i,
  input  wire logic          si_i,
  input  wire logic [4:0]    protect_lvl_i,
  input  wire logic [7:0]    pbuf_rd_addr_i,
  input  wire logic [23:0]   qread_start_addr_i,
  input  wire logic [23:0]   qread_offset_i,
  output logic               write_busy_o,
  output logic               write_enable_latch_o,
  output wrap_cfg_type       wrap_cfg_o,
  output array_cmd_type      array_cmd_o,
  output logic               array_start_o,
  output logic [7:0]         pbuf_rd_data_o,
  output logic               pbuf_rd_keep_o,
  output logic [23:0]        qread_addr_o
);

  logic [2:0]    sync1_reg;
  logic [2:0]    sync2_reg;
  logic          sclk_prev_reg;
  logic          cs_prev_reg;
  logic          sclk_rise;
  logic          cs_rise;
  logic          cs_fall;
  logic [2:0]    bit_cnt_reg;
  logic [2:0]    byte_cnt_reg;
  logic [7:0]    shift_reg;
  logic [7:0]    shift_next;
  logic [7:0]    opcode_reg;
  logic [23:0]   addr_reg;
  logic [7:0]    wrap_byte_reg;
  logic [7:0]    wr_ptr_reg;
  logic [255:0]  keep_reg;
  logic          byte_done;
  logic          data_wr;
  logic          wel_reg;
  logic          exact_end;
  logic          addr_protected;
  logic          bp_clear;
  op_kind_type   commit_kind;
  logic          commit_start;
  logic          commit_wel;
  logic          commit_wrap;
  seq_state_type state_reg;
  logic [31:0]   cycle_cnt_reg;
  logic [31:0]   cycle_load;
  wrap_cfg_type  wrap_reg;
  logic [7:0]    wrap_mask;
  logic [7:0]    wrap_low;

  // two flops on every pin input: cs_n, sclk, si
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
    end else begin
      sync1_reg <= {cs_n_i, sclk_i, si_i};
      sync2_reg <= sync1_reg;
    end
  end

  // edge history taken from the second stage only
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_prev_reg <= 1'b1;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sync2_reg[1];
      cs_prev_reg   <= sync2_reg[2];
    end
  end

  assign sclk_rise  = sync2_reg[1] & ~sclk_prev_reg & ~sync2_reg[2];
  assign cs_rise    = sync2_reg[2] & ~cs_prev_reg;
  assign cs_fall    = ~sync2_reg[2] & cs_prev_reg;
  assign shift_next = {shift_reg[6:0], sync2_reg[0]};
  assign byte_done  = sclk_rise & (bit_cnt_reg == 3'h7);

  // bit and byte counting; a chip select glitch restarts the frame, so
  // a host that lets it rise mid-command loses the command
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      shift_reg    <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (sclk_rise) begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done && byte_cnt_reg != `BYTES_SATURATE) begin
        byte_cnt_reg <= byte_cnt_reg + 3'h1;
      end
    end
  end

  // opcode, address and wrap byte capture
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      opcode_reg    <= 8'h00;
      addr_reg      <= 24'h00_0000;
      wrap_byte_reg <= 8'h00;
    end else if (byte_done) begin
      case (byte_cnt_reg)
        3'h0: opcode_reg <= shift_next;
        3'h1, 3'h2, 3'h3: addr_reg <= {addr_reg[15:0], shift_next};
        3'h4: wrap_byte_reg <= shift_next;
        default: wrap_byte_reg <= wrap_byte_reg;
      endcase
    end
  end

  // page write data goes to the buffer; a running program reads that
  // buffer, so nothing is written into it while busy
  assign data_wr = byte_done & (opcode_reg == `OPC_PAGE_WRITE) &
                   (byte_cnt_reg >= `BYTES_ADDR_END) &
                   (state_reg == ST_READY);

  // write pointer starts at the addressed byte and wraps in the page
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr_reg <= 8'h00;
    end else if (byte_done && byte_cnt_reg == 3'h3) begin
      wr_ptr_reg <= shift_next;
    end else if (data_wr) begin
      wr_ptr_reg <= wr_ptr_reg + 8'h01;
    end
  end

  // keep flags: only bytes that arrived are programmed; later bytes
  // overwrite earlier ones at the same offset, so the last 256 survive
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      keep_reg <= '0;
    end else if (byte_done && byte_cnt_reg == 3'h3 &&
                 state_reg == ST_READY) begin
      keep_reg <= '0;
    end else if (data_wr) begin
      keep_reg[wr_ptr_reg] <= 1'b1;
    end
  end

  page_buffer_mem u_page_buffer (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .wr_en_i   (data_wr),
    .wr_addr_i (wr_ptr_reg),
    .wr_data_i (shift_next),
    .rd_addr_i (pbuf_rd_addr_i),
    .rd_data_o (pbuf_rd_data_o)
  );

  // keep flag for the byte the array reads, aligned with the data
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pbuf_rd_keep_o <= 1'b0;
    end else begin
      pbuf_rd_keep_o <= keep_reg[pbuf_rd_addr_i];
    end
  end

  // block protection: levels 1..4 guard 1,2,4,8 blocks, 5 and up all;
  // protect_lvl_4 moves the guarded span from the top to the bottom
  function automatic logic region_guarded(input logic [4:0] lvl,
                                          input logic [3:0] blk);
    logic [4:0] span;
    span = 5'h00;
    if (lvl[3:0] >= `PROTECT_ALL_LVL) begin
      span = `BLOCK_COUNT;
    end else if (lvl[3:0] != 4'h0) begin
      span = 5'h01 << (lvl[3:0] - 4'h1);
    end
    if (lvl[4]) begin
      region_guarded = ({1'b0, blk} < span);
    end else begin
      region_guarded = ({1'b0, blk} >= (`BLOCK_COUNT - span));
    end
  endfunction

  assign addr_protected = region_guarded(protect_lvl_i,
    addr_reg[`BLOCK_IDX_HI:`BLOCK_IDX_LO]);
  assign bp_clear  = (protect_lvl_i == 5'h00);
  assign exact_end = (bit_cnt_reg == 3'h0);

  // decode at chip select release: kind and frame length check
  always_comb begin
    commit_kind = OP_NONE;
    commit_wel  = 1'b0;
    commit_wrap = 1'b0;
    case (opcode_reg)
      `OPC_WRITE_EN: begin
        commit_wel = (byte_cnt_reg == `BYTES_OPCODE_ONLY) & exact_end;
      end
      `OPC_WRAP_SET: begin
        commit_wrap = (byte_cnt_reg == `BYTES_WRAP_END) & exact_end;
      end
      `OPC_PAGE_CLEAR: begin
        if (byte_cnt_reg == `BYTES_ADDR_END && exact_end) begin
          commit_kind = OP_PAGE_CLEAR;
        end
      end
      `OPC_MID_WIPE: begin
        if (byte_cnt_reg == `BYTES_ADDR_END && exact_end) begin
          commit_kind = OP_MID_WIPE;
        end
      end
      `OPC_HALF_CLEAR: begin
        if (byte_cnt_reg == `BYTES_ADDR_END && exact_end) begin
          commit_kind = OP_HALF_CLEAR;
        end
      end
      `OPC_REGION_CLEAR: begin
        if (byte_cnt_reg == `BYTES_ADDR_END && exact_end) begin
          commit_kind = OP_REGION_CLEAR;
        end
      end
      `OPC_WHOLE_CLEAR_A, `OPC_WHOLE_CLEAR_B: begin
        if (byte_cnt_reg == `BYTES_OPCODE_ONLY && exact_end &&
            bp_clear) begin
          commit_kind = OP_WHOLE_CLEAR;
        end
      end
      `OPC_PAGE_WRITE: begin
        if (byte_cnt_reg >= `BYTES_WRAP_END && exact_end) begin
          commit_kind = OP_PAGE_WRITE;
        end
      end
      default: commit_kind = OP_NONE;
    endcase
  end

  // a start needs the latch, a free sequencer and an unguarded region
  assign commit_start = cs_rise & (commit_kind != OP_NONE) & wel_reg &
                        (state_reg == ST_READY) &
                        ((commit_kind == OP_WHOLE_CLEAR) | ~addr_protected);

  // cycle length per operation
  always_comb begin
    case (commit_kind)
      OP_PAGE_CLEAR:   cycle_load = 32'(PAGE_CLEAR_CYCLES);
      OP_MID_WIPE:     cycle_load = 32'(MID_CLEAR_CYCLES);
      OP_HALF_CLEAR:   cycle_load = 32'(HALF_CLEAR_CYCLES);
      OP_REGION_CLEAR: cycle_load = 32'(REGION_CLEAR_CYCLES);
      OP_WHOLE_CLEAR:  cycle_load = 32'(WHOLE_CLEAR_CYCLES);
      OP_PAGE_WRITE:   cycle_load = 32'(PAGE_WRITE_CYCLES);
      default:         cycle_load = 32'h0000_0001;
    endcase
  end

  // self-timed cycle: busy from the start until the count runs out
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg     <= ST_READY;
      cycle_cnt_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_READY: begin
          if (commit_start) begin
            state_reg     <= ST_RUN;
            cycle_cnt_reg <= cycle_load;
          end
        end
        ST_RUN: begin
          if (cycle_cnt_reg <= 32'h0000_0001) begin
            state_reg     <= ST_READY;
            cycle_cnt_reg <= 32'h0000_0000;
          end else begin
            cycle_cnt_reg <= cycle_cnt_reg - 32'h0000_0001;
          end
        end
        default: state_reg <= ST_READY;
      endcase
    end
  end

  assign write_busy_o = (state_reg == ST_RUN);

  // write enable latch: set by a clean 06h frame while idle, dropped
  // as the internal cycle begins, well before it ends
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wel_reg <= 1'b0;
    end else if (commit_start) begin
      wel_reg <= 1'b0;
    end else if (cs_rise && commit_wel && state_reg == ST_READY) begin
      wel_reg <= 1'b1;
    end
  end

  assign write_enable_latch_o = wel_reg;

  // command to the array, one-cycle start pulse
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      array_cmd_o   <= '{kind: OP_NONE, addr: 24'h00_0000};
      array_start_o <= 1'b0;
    end else begin
      array_start_o <= commit_start;
      if (commit_start) begin
        array_cmd_o <= '{kind: commit_kind, addr: addr_reg};
      end
    end
  end

  // wrap setting, refused while busy
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wrap_reg <= {`WRAP_OFF_RESET, `WRAP_LEN_RESET};
    end else if (cs_rise && commit_wrap && state_reg == ST_READY) begin
      wrap_reg.wrap_off    <= wrap_byte_reg[`WRAP_OFF_POS];
      wrap_reg.wrap_len_hi <= wrap_byte_reg[`WRAP_LEN_HI_POS];
      wrap_reg.wrap_len_lo <= wrap_byte_reg[`WRAP_LEN_LO_POS];
    end
  end

  assign wrap_cfg_o = wrap_reg;

  // section mask: 8, 16, 32 or 64 bytes
  always_comb begin
    case ({wrap_reg.wrap_len_hi, wrap_reg.wrap_len_lo})
      2'b00:   wrap_mask = 8'h07;
      2'b01:   wrap_mask = 8'h0F;
      2'b10:   wrap_mask = 8'h1F;
      default: wrap_mask = 8'h3F;
    endcase
  end

  assign wrap_low = qread_start_addr_i[7:0] + qread_offset_i[7:0];

  // quad read address: wrapped inside the aligned section, else linear
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      qread_addr_o <= 24'h00_0000;
    end else if (!wrap_reg.wrap_off) begin
      qread_addr_o <= {qread_start_addr_i[23:8],
        (qread_start_addr_i[7:0] & ~wrap_mask) | (wrap_low & wrap_mask)};
    end else begin
      qread_addr_o <= qread_start_addr_i + qread_offset_i;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_wrap_commit;
    cs_rise && commit_wrap && !write_busy_o;
  endsequence

  sequence s_run_begins;
    commit_start ##1 write_busy_o;
  endsequence

  a_wrap_capture: assert property (
    s_wrap_commit |=>
      wrap_cfg_o == {$past(wrap_byte_reg[`WRAP_OFF_POS]),
                     $past(wrap_byte_reg[`WRAP_LEN_HI_POS]),
                     $past(wrap_byte_reg[`WRAP_LEN_LO_POS])})
    else $error("wrap setting not taken from wrap byte");

  a_wrap_section: assert property (
    !wrap_cfg_o.wrap_off && $stable(wrap_cfg_o) |=>
      qread_addr_o[23:6] == $past(qread_start_addr_i[23:6]))
    else $error("wrapped read left its section");

  a_wrap_linear: assert property (
    wrap_cfg_o.wrap_off |=>
      qread_addr_o == $past(qread_start_addr_i) + $past(qread_offset_i))
    else $error("linear read address wrong");

  a_start_needs_wel: assert property (
    array_start_o |-> $past(wel_reg))
    else $error("cycle started without write enable");

  a_busy_follows: assert property (
    commit_start |=> write_busy_o && array_start_o)
    else $error("cycle did not start after valid command");

  a_busy_holds: assert property (
    s_run_begins ##0 (cycle_cnt_reg > 32'h0000_0002) |=>
      write_busy_o [*2])
    else $error("write_busy dropped early");

  a_wel_dropped: assert property (
    s_run_begins |-> !write_enable_latch_o)
    else $error("write enable latch kept during cycle");

  a_guard_region: assert property (
    array_start_o && array_cmd_o.kind != OP_WHOLE_CLEAR |->
      !$past(addr_protected))
    else $error("protected region selected");

  a_whole_guard: assert property (
    array_start_o && array_cmd_o.kind == OP_WHOLE_CLEAR |->
      $past(protect_lvl_i) == 5'h00)
    else $error("whole clear with protection set");

  a_busy_ignores: assert property (
    write_busy_o |=> !array_start_o && $stable(array_cmd_o))
    else $error("command accepted while busy");

endmodule

// File: include/flash_seq_defines.svh
/*
  Constants of the serial flash command sequencer: opcodes, frame lengths,
  wrap-byte fields, reset values and internal cycle times.
  Assumes it is included by its bare name and only once per unit.
*/
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// command opcodes
`define OPC_WRITE_EN        8'h06
`define OPC_WRAP_SET        8'h77
`define OPC_PAGE_CLEAR      8'h81
`define OPC_MID_WIPE        8'h20
`define OPC_HALF_CLEAR      8'h52
`define OPC_REGION_CLEAR    8'hD8
`define OPC_WHOLE_CLEAR_A   8'h60
`define OPC_WHOLE_CLEAR_B   8'hC7
`define OPC_PAGE_WRITE      8'h02

// whole bytes seen when chip select rises (opcode counts as one)
`define BYTES_OPCODE_ONLY   3'h1
`define BYTES_ADDR_END      3'h4
`define BYTES_WRAP_END      3'h5
`define BYTES_SATURATE      3'h6

// field positions inside the wrap byte
`define WRAP_OFF_POS        4
`define WRAP_LEN_LO_POS     5
`define WRAP_LEN_HI_POS     6

// reset values
`define WRAP_OFF_RESET      1'h1
`define WRAP_LEN_RESET      2'h0

// block protection: 16 blocks of 64 KiB, index in address bits 19:16
`define BLOCK_IDX_HI        19
`define BLOCK_IDX_LO        16
`define BLOCK_COUNT         5'h10
`define PROTECT_ALL_LVL     4'h5

// clock period and internal cycle times
`define CLK_PERIOD_NS       5
`define PAGE_CLEAR_TIME_US  8000
`define MID_CLEAR_TIME_US   30000
`define HALF_CLEAR_TIME_US  100000
`define REGION_CLEAR_TIME_US 150000
`define WHOLE_CLEAR_TIME_US 20000
`define PAGE_WRITE_TIME_US  2000

`endif

// File: include/flash_seq_pkg.sv
/*
  Types shared by the flash command sequencer and its testbench.
  Assumes the defines header is available on the include path.
*/
package flash_seq_pkg;

  // internal self-timed operation kinds
  typedef enum logic [2:0] {
    OP_NONE         = 3'b000,
    OP_PAGE_CLEAR   = 3'b001,
    OP_MID_WIPE     = 3'b010,
    OP_HALF_CLEAR   = 3'b011,
    OP_REGION_CLEAR = 3'b100,
    OP_WHOLE_CLEAR  = 3'b101,
    OP_PAGE_WRITE   = 3'b110
  } op_kind_type;

  // sequencer state
  typedef enum logic [0:0] {
    ST_READY = 1'b0,
    ST_RUN   = 1'b1
  } seq_state_type;

  // burst-wrap setting
  typedef struct packed {
    logic       wrap_off;
    logic       wrap_len_hi;
    logic       wrap_len_lo;
  } wrap_cfg_type;

  // command handed to the array
  typedef struct packed {
    op_kind_type kind;
    logic [23:0] addr;
  } array_cmd_type;

endpackage

// File: hdl/page_buffer_mem.sv
/*
  256 x 8 page buffer, one write port, one read port with registered data.
  Assumes both ports run on the sequencer clock.
*/
`timescale 1ns/1ps

module page_buffer_mem (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic [7:0] rd_addr_i,
  output logic      [7:0] rd_data_o
);

  logic [7:0] mem_reg [256];

  // storage carries no reset; only written bytes are ever flagged valid
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  // registered read port
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= mem_reg[rd_addr_i];
    end
  end

endmodule

// File: testbench/spi_host_model.sv
/*
  spi host model: drives chip select, serial clock and data for one frame.
  assumes it is called from the bench's main process on the 200 MHz clock.
*/
`timescale 1ns/1ps

module spi_host_model (
  input  wire logic sys_clk_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      si_o
);
  // serial clock idles high and stands still between frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b1;
    si_o   = 1'b0;
  end

  // one half period of the 160 ns serial clock
  task automatic half();
    repeat (16) @(posedge sys_clk_i);
  endtask

  // bytes msb first; cut drops trailing bits to break the framing
  task automatic send(input logic [7:0] b [$], input int cut);
    int n;
    n = b.size() * 8 - cut;
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      half();
      sclk_o <= 1'b0;
      si_o   <= b[i / 8][7 - i % 8];
      half();
      sclk_o <= 1'b1;
    end
    half();
    cs_n_o <= 1'b1;
    si_o   <= ~si_o; // released line must not keep its old level
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule

// File: testbench/flash_cmd_seq_tb.sv
/*
  self-checking bench for the flash command sequencer.
  assumes the host model drives the serial pins and that shortened cycle
  counts keep every self-timed cycle to a few hundred clocks.
*/
`timescale 1ns/1ps
`include "flash_seq_defines.svh"

module flash_cmd_seq_tb import flash_seq_pkg::*; ;
  localparam int          CYC [6] = '{20, 600, 28, 32, 36, 36};
  localparam int          PW      = 40;
  localparam logic [7:0]  OPC [6] = '{`OPC_PAGE_CLEAR, `OPC_MID_WIPE,
    `OPC_HALF_CLEAR, `OPC_REGION_CLEAR, `OPC_WHOLE_CLEAR_A,
    `OPC_WHOLE_CLEAR_B};
  localparam op_kind_type KND [6] = '{OP_PAGE_CLEAR, OP_MID_WIPE,
    OP_HALF_CLEAR, OP_REGION_CLEAR, OP_WHOLE_CLEAR, OP_WHOLE_CLEAR};

  typedef struct packed {
    array_cmd_type cmd;
    logic [15:0]   n;
  } note_type;

  logic          sys_clk_i   = 1'b0;
  logic          reset_i     = 1'b1;
  logic          cs_n, sclk, si, busy, write_enable_latch, start, keep;
  logic [4:0]    protect_lvl = 5'h00;
  logic [7:0]    rd_addr     = 8'h00;
  logic [23:0]   q_start     = 24'h00_0000;
  logic [23:0]   q_off       = 24'h00_0000;
  wrap_cfg_type  wrap_cfg;
  array_cmd_type acmd;
  logic [7:0]    rd_data, m, wb;
  logic [23:0]   qmap, e, a;
  logic [15:0]   cnt;
  logic [7:0]    d [5];
  note_type      notes [$];
  note_type      cur;
  int            n_errors = 0;
  int            total_checks = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  flash_cmd_seq #(
    .PAGE_CLEAR_CYCLES   (CYC[0]),
    .MID_CLEAR_CYCLES    (CYC[1]),
    .HALF_CLEAR_CYCLES   (CYC[2]),
    .REGION_CLEAR_CYCLES (CYC[3]),
    .WHOLE_CLEAR_CYCLES  (CYC[4]),
    .PAGE_WRITE_CYCLES   (PW)
  ) i_flash_cmd_seq (
    .sys_clk_i            (sys_clk_i),
    .reset_i              (reset_i),
    .cs_n_i               (cs_n),
    .sclk_i               (sclk),
    .si_i                 (si),
    .protect_lvl_i        (protect_lvl),
    .pbuf_rd_addr_i       (rd_addr),
    .qread_start_addr_i   (q_start),
    .qread_offset_i       (q_off),
    .write_busy_o         (busy),
    .write_enable_latch_o (write_enable_latch),
    .wrap_cfg_o           (wrap_cfg),
    .array_cmd_o          (acmd),
    .array_start_o        (start),
    .pbuf_rd_data_o       (rd_data),
    .pbuf_rd_keep_o       (keep),
    .qread_addr_o         (qmap)
  );

  spi_host_model i_spi_host_model (
    .sys_clk_i (sys_clk_i),
    .cs_n_o    (cs_n),
    .sclk_o    (sclk),
    .si_o      (si)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s %h vs %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // bounded wait for the self-timed cycle, then let the monitor finish
  task automatic idle();
    tick(8);
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) tick(1);
    tick(2);
    check(busy, 1'b0, "busy stuck");
  endtask

  task automatic tx(input logic [7:0] b [$], input int cut);
    i_spi_host_model.send(b, cut);
  endtask

  task automatic frame4(input logic [7:0] op, input logic [23:0] ad,
                        input int cut);
    tx({op, ad[23:16], ad[15:8], ad[7:0]}, cut);
  endtask

  task automatic note(input op_kind_type k, input logic [23:0] ad,
                      input int n);
    notes.push_back('{'{k, ad}, n[15:0]});
  endtask

  task automatic wen();
    tx({`OPC_WRITE_EN}, 0);
    check(write_enable_latch, 1'b1, "latch set");
  endtask

  // every start must match the oldest expected command
  always @(posedge sys_clk_i) begin
    if (start === 1'b1) begin
      if (notes.size() == 0) begin
        check(1'b1, 1'b0, "start not expected");
      end else begin
        cur = notes.pop_front();
        check(acmd.kind, cur.cmd.kind, "kind");
        if (cur.cmd.kind != OP_WHOLE_CLEAR)
          check(acmd.addr, cur.cmd.addr, "address");
        check(write_enable_latch, 1'b0, "latch in cycle");
        cnt = 16'h0000;
        while (busy === 1'b1) begin
          cnt++;
          @(posedge sys_clk_i);
        end
        check(cnt, cur.n, "busy length");
      end
    end
  end

  // watchdog sized well above the expected run of about 25k clocks
  initial begin
    tick(60000);
    n_errors++;
    $display("unexpected at %0t: run timed out", $time);
    wrap_up();
  end

  initial begin
    void'($urandom(46366));
    tick(2);
    reset_i <= 1'b0;
    tick(4);
    // wrapping is off and nothing is latched or running out of reset
    check(wrap_cfg, {`WRAP_OFF_RESET, `WRAP_LEN_RESET}, "wrap reset");
    check(write_enable_latch, 1'b0, "latch reset");
    check(busy, 1'b0, "busy reset");
    // four wrap lengths, then wrap off again
    for (int w = 0; w < 5; w++) begin
      wb = (w == 4) ? 8'h10 : {1'b0, w[1:0], 5'h00};
      tx({`OPC_WRAP_SET, 8'h00, 8'h00, 8'h00, wb}, 0);
      check(wrap_cfg, {wb[4], wb[6], wb[5]}, "wrap byte");
      q_start <= 24'($urandom);
      q_off   <= 24'($urandom);
      tick(3);
      m = (8'h08 << w[1:0]) - 8'h01;
      e = wb[4] ? q_start + q_off
                : {q_start[23:8], (q_start[7:0] & ~m)
                   | ((q_start[7:0] + q_off[7:0]) & m)};
      check(qmap, e, "quad read address");
    end
    // every clear opcode on a random unprotected address
    for (int i = 0; i < 6; i++) begin
      wen();
      a = 24'($urandom) & 24'h0F_FFFF;
      note(KND[i], a, CYC[i]);
      if (i < 4)
        frame4(OPC[i], a, 0);
      else
        tx({OPC[i]}, 0);
      idle();
    end
    // page write that runs past the page end
    wen();
    a = 24'($urandom);
    a[7:0] = 8'hFE;
    for (int k = 0; k < 5; k++) d[k] = 8'($urandom);
    note(OP_PAGE_WRITE, a, PW);
    tx({`OPC_PAGE_WRITE, a[23:16], a[15:8], a[7:0],
        d[0], d[1], d[2], d[3], d[4]}, 0);
    idle();
    for (int k = 0; k < 6; k++) begin
      rd_addr <= 8'hFE + k[7:0];
      tick(2);
      check(keep, k < 5, "kept byte");
      if (k < 5) check(rd_data, d[k], "buffer byte");
    end
    // refused frames: no latch, short, long, protected, partial byte
    frame4(`OPC_PAGE_CLEAR, a, 0);
    wen();
    frame4(`OPC_PAGE_CLEAR, a, 1);
    tx({`OPC_MID_WIPE, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    protect_lvl <= 5'h01;
    frame4(`OPC_REGION_CLEAR, 24'h0F_0000, 0);
    tx({`OPC_WHOLE_CLEAR_A}, 0);
    protect_lvl <= 5'h00;
    tx({`OPC_PAGE_WRITE, 8'h00, 8'h00, 8'h00, 8'h5A}, 3);
    check(write_enable_latch, 1'b1, "latch kept");
    // a latch request during a long cycle is dropped
    note(OP_MID_WIPE, 24'h00_1000, CYC[1]);
    frame4(`OPC_MID_WIPE, 24'h00_1000, 0);
    tx({`OPC_WRITE_EN}, 0);
    check(write_enable_latch, 1'b0, "latch while busy");
    idle();
    check(notes.size(), 0, "missing starts");
    wrap_up();
  end
endmodule
